// [design/sfpfe_pkg.sv]
// Purpose: shared constants and types for the serial flash pin front end
// Assumes: both ends include this package; data lines are numbered 0..3
// Notes:   no registers reachable by software; configuration is by pins
package sfpfe_pkg;

	// =====================================================================
	// widths and depths
	localparam int BYTE_W     = 8;
	localparam int LINE_CNT   = 4;
	localparam int SYNC_W     = 7;
	localparam int FIFO_DEPTH = 16;
	localparam int HALF_DIV   = 8;

	// =====================================================================
	// data line roles in single-line mode
	localparam int LINE_SI    = 0;
	localparam int LINE_SO    = 1;
	localparam int LINE_WP    = 2;
	localparam int LINE_PAUSE = 3;

	// =====================================================================
	// bit counting per clock edge, and output-enable masks
	localparam logic [3:0] LANES_ONE  = 4'h1;
	localparam logic [3:0] LANES_FOUR = 4'h4;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [3:0] OE_NONE    = 4'h0;
	localparam logic [3:0] OE_ALL     = 4'hf;
	localparam logic [3:0] OE_SO      = 4'h2;

	// =====================================================================
	// array organisation
	localparam logic [23:0] SECTOR_BYTES    = 24'h001000;
	localparam int          BLOCK32_SECTORS = 8;
	localparam int          BLOCK64_SECTORS = 16;

	// =====================================================================
	// host sequencer states, one-hot
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_GAP  = 4'h2,
		H_LOW  = 4'h4,
		H_HIGH = 4'h8
	} sfpfe_host_state_t;

	// sector and block numbers of a byte address
	function automatic logic [11:0] sfpfeSectorOf(input logic [23:0] addr);
		sfpfeSectorOf = addr[23:12];
	endfunction

	function automatic logic [7:0] sfpfeBlock64Of(input logic [23:0] addr);
		sfpfeBlock64Of = addr[23:16];
	endfunction

endpackage

// [design/sfpfe_link_if.sv]
// Purpose: pin bundle between master and flash front end
// Assumes: data lines are pulled up when nobody drives them
// Notes:   resolves each two-way line from both output enables
`timescale 1ns/1ps
`default_nettype none
interface sfpfe_link_if;
	logic       sck;
	logic       csN;
	logic       hwResetN;
	logic [3:0] hostOut;
	logic [3:0] hostOe;
	logic [3:0] devOut;
	logic [3:0] devOe;
	logic [3:0] lineLevel;

	// =====================================================================
	// wire level per line; device wins if both drive (a bus fight anyway)
	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : gLine
			assign lineLevel[i] = devOe[i] ? devOut[i] :
				(hostOe[i] ? hostOut[i] : 1'b1);
		end
	endgenerate

	modport device (
		input  sck,
		input  csN,
		input  hwResetN,
		input  lineLevel,
		output devOut,
		output devOe
	);

	modport host (
		output sck,
		output csN,
		output hwResetN,
		output hostOut,
		output hostOe,
		input  lineLevel
	);
endinterface
`default_nettype wire

// [design/sfpfe_device_end.sv]
// Purpose: flash-side pin front end: sampling, pause, reset, lane muxing
// Assumes: ref_clk much faster than the serial clock (8x or more)
// Notes:   received bytes go through a FIFO; a full FIFO drops bytes
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// small flop FIFO; depth must be a power of two
module sfpfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             doWrite;
	logic             doRead;

	// honest full and empty from the occupancy count
	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;
	assign outData  = mem_q[rdPtr_q];

	// pointers and count
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doRead)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (doWrite && !doRead)
				count_q <= count_q + 1'b1;
			else if (doRead && !doWrite)
				count_q <= count_q - 1'b1;
		end
	end

	// storage carries no reset: contents are meaningless until written
	always_ff @(posedge ref_clk)
	begin
		if (doWrite)
			mem_q[wrPtr_q] <= inData;
	end
endmodule

// =========================================================================
// flash-side end
module sfpfe_device_end
	import sfpfe_pkg::*;
#(
	parameter int RX_DEPTH = FIFO_DEPTH
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	sfpfe_link_if.device           link,
	input  wire logic              quadEnableBit,
	input  wire logic              fourWireCommandMode,
	input  wire logic [BYTE_W-1:0] txData,
	input  wire logic              txValid,
	output logic                   txTaken,
	output logic [BYTE_W-1:0]      rxData,
	output logic                   rxValid,
	input  wire logic              rxReady,
	output logic                   rxRoom,
	output logic                   selected,
	output logic                   paused,
	output logic                   inReset
);
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic              sckPrev_q;
	logic              activePrev_q;
	logic              armed_q;
	logic [3:0]        bitCnt_q;
	logic [BYTE_W-1:0] rxShift_q;
	logic [BYTE_W-1:0] rxByte_q;
	logic              rxPush_q;
	logic              riseSeen_q;
	logic              loadPend_q;
	logic [BYTE_W-1:0] txShift_q;
	logic              drive_q;
	logic              txTaken_q;
	logic              sckS;
	logic              csNS;
	logic              rstNS;
	logic [3:0]        lineS;
	logic              quad;
	logic [3:0]        lanes;
	logic              pauseNow;
	logic              active;
	logic              step;
	logic              sckRise;
	logic              sckFall;
	logic              byteDone;
	logic              startLoad;
	logic              fallShift;

	// =====================================================================
	// pin synchronisers: meta_q feeds sync_q and nothing else
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= {link.hwResetN, link.csN, link.sck, link.lineLevel};
			sync_q <= meta_q;
		end
	end

	assign lineS = sync_q[3:0];
	assign sckS  = sync_q[4];
	assign csNS  = sync_q[5];
	assign rstNS = sync_q[6];

	// edge history of the sampled serial clock and of selection
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sckPrev_q    <= 1'b0;
			activePrev_q <= 1'b0;
		end
		else
		begin
			sckPrev_q    <= sckS;
			activePrev_q <= active;
		end
	end

	// =====================================================================
	// mode decode
	assign quad  = fourWireCommandMode;
	assign lanes = quad ? LANES_FOUR : LANES_ONE;
	// pause pin is a data line once quad enable or four-wire mode is on
	assign pauseNow = !quadEnableBit && !quad && !csNS
		&& !lineS[LINE_PAUSE];
	assign active   = armed_q && !csNS && rstNS;
	// while paused no edge is counted, so state simply waits
	assign step      = active && !pauseNow;
	// mode 0 and 3 differ only in idle level; edges alone matter
	assign sckRise   = sckS && !sckPrev_q;
	assign sckFall   = !sckS && sckPrev_q;
	assign byteDone  = step && sckRise && (bitCnt_q + lanes == BYTE_BITS);
	assign startLoad = active && !activePrev_q;
	assign fallShift = step && sckFall && riseSeen_q;

	// arm only after select has been seen high since any reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !rstNS)
			armed_q <= 1'b0;
		else if (csNS)
			armed_q <= 1'b1;
	end

	// =====================================================================
	// receive: capture on rising edges, first bit is the top bit
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !active)
		begin
			bitCnt_q  <= '0;
			rxShift_q <= '0;
		end
		else if (step && sckRise)
		begin
			if (quad)
				rxShift_q <= {rxShift_q[3:0], lineS};
			else
				rxShift_q <= {rxShift_q[6:0], lineS[LINE_SI]};
			bitCnt_q <= byteDone ? 4'h0 : bitCnt_q + lanes;
		end
	end

	// completed byte handed to the FIFO one cycle later
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rxPush_q <= 1'b0;
			rxByte_q <= '0;
		end
		else
		begin
			rxPush_q <= byteDone;
			if (byteDone)
				rxByte_q <= quad ? {rxShift_q[3:0], lineS} :
					{rxShift_q[6:0], lineS[LINE_SI]};
		end
	end

	sfpfe_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (RX_DEPTH)
	) uRxFifo (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.inData   (rxByte_q),
		.inValid  (rxPush_q),
		.inReady  (rxRoom),
		.outData  (rxData),
		.outValid (rxValid),
		.outReady (rxReady)
	);

	// =====================================================================
	// transmit: a fall only shifts after a rise consumed the bit, so the
	// leading fall of mode 3 does not skip the first bit
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !active)
			riseSeen_q <= 1'b0;
		else if (step && sckRise)
			riseSeen_q <= 1'b1;
		else if (step && sckFall)
			riseSeen_q <= 1'b0;
	end

	// next byte is loaded at the fall that follows a completed byte
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !active)
			loadPend_q <= 1'b0;
		else if (byteDone)
			loadPend_q <= 1'b1;
		else if (fallShift)
			loadPend_q <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			txShift_q <= '0;
			drive_q   <= 1'b0;
			txTaken_q <= 1'b0;
		end
		else
		begin
			txTaken_q <= 1'b0;
			if (startLoad || (fallShift && loadPend_q))
			begin
				txShift_q <= txData;
				drive_q   <= txValid;
				txTaken_q <= txValid;
			end
			else if (fallShift)
			begin
				if (quad)
					txShift_q <= {txShift_q[3:0], 4'h0};
				else
					txShift_q <= {txShift_q[6:0], 1'b0};
			end
		end
	end

	// =====================================================================
	// pin drive: floats when deselected, paused or held in reset
	assign link.devOut = quad ? txShift_q[7:4] :
		{2'b00, txShift_q[7], 1'b0};
	assign link.devOe  = (active && !pauseNow && drive_q) ?
		(quad ? OE_ALL : OE_SO) : OE_NONE;

	assign txTaken  = txTaken_q;
	assign selected = active;
	assign paused   = active && pauseNow;
	assign inReset  = !rstNS;
endmodule
`default_nettype wire

// [design/sfpfe_host_end.sv]
// Purpose: master-side end: clock divider, select, pause and reset drive
// Assumes: device end samples every pin through two flops
// Notes:   half period must cover the device round trip; keep >= 8
`timescale 1ns/1ps
`default_nettype none
module sfpfe_host_end
	import sfpfe_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_DIV
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	sfpfe_link_if.host             link,
	input  wire logic              cpolHigh,
	input  wire logic              quadEnableBit,
	input  wire logic              fourWireCommandMode,
	input  wire logic              selectReq,
	input  wire logic              pauseReq,
	input  wire logic              hwResetReq,
	input  wire logic              readDir,
	input  wire logic [BYTE_W-1:0] txData,
	input  wire logic              txValid,
	output logic                   txReady,
	output logic [BYTE_W-1:0]      rxData,
	output logic                   rxValid,
	output logic                   busy
);
	sfpfe_host_state_t state_q;
	logic [3:0]        meta_q;
	logic [3:0]        lineS_q;
	logic [15:0]       halfCnt_q;
	logic [3:0]        bitCnt_q;
	logic [BYTE_W-1:0] txShift_q;
	logic [BYTE_W-1:0] rxShift_q;
	logic [BYTE_W-1:0] rxData_q;
	logic              rxValid_q;
	logic              txReady_q;
	logic              sck_q;
	logic              csN_q;
	logic              hwReset_q;
	logic              quad;
	logic [3:0]        lanes;
	logic              inFrame;
	logic              holdPause;
	logic              halfDone;

	assign quad      = fourWireCommandMode;
	assign lanes     = quad ? LANES_FOUR : LANES_ONE;
	assign inFrame   = state_q != H_IDLE;
	assign holdPause = pauseReq && !quadEnableBit && !quad && inFrame;
	assign halfDone  = halfCnt_q == 16'(HALF_CYCLES - 1);

	// =====================================================================
	// returning data lines come from the device's domain
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			meta_q  <= '0;
			lineS_q <= '0;
		end
		else
		begin
			meta_q  <= link.lineLevel;
			lineS_q <= meta_q;
		end
	end

	// caller must not request reset during an internal write
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			hwReset_q <= 1'b0;
		else
			hwReset_q <= hwResetReq;
	end

	// =====================================================================
	// sequencer: each bit cell is a low half then a high half
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || hwResetReq)
		begin
			state_q   <= H_IDLE;
			csN_q     <= 1'b1;
			sck_q     <= cpolHigh;
			halfCnt_q <= '0;
			bitCnt_q  <= '0;
			txShift_q <= '0;
			rxShift_q <= '0;
			rxData_q  <= '0;
			rxValid_q <= 1'b0;
			txReady_q <= 1'b0;
		end
		else
		begin
			rxValid_q <= 1'b0;
			txReady_q <= 1'b0;
			case (state_q)
				H_IDLE:
				begin
					sck_q <= cpolHigh;
					if (selectReq)
					begin
						csN_q   <= 1'b0;
						state_q <= H_GAP;
					end
				end
				H_GAP:
				begin
					if (!selectReq)
					begin
						csN_q   <= 1'b1;
						state_q <= H_IDLE;
					end
					else if (txValid || readDir)
					begin
						txShift_q <= txData;
						txReady_q <= txValid;
						bitCnt_q  <= '0;
						halfCnt_q <= '0;
						sck_q     <= 1'b0;
						state_q   <= H_LOW;
					end
				end
				H_LOW:
				begin
					if (!holdPause)
					begin
						halfCnt_q <= halfDone ? 16'h0000 :
							halfCnt_q + 16'h0001;
						if (halfDone)
						begin
							// sample just ahead of the rising edge
							rxShift_q <= quad ? {rxShift_q[3:0], lineS_q} :
								{rxShift_q[6:0], lineS_q[LINE_SO]};
							sck_q   <= 1'b1;
							state_q <= H_HIGH;
						end
					end
				end
				H_HIGH:
				begin
					if (!holdPause)
					begin
						halfCnt_q <= halfDone ? 16'h0000 :
							halfCnt_q + 16'h0001;
						if (halfDone && (bitCnt_q + lanes == BYTE_BITS))
						begin
							rxData_q  <= rxShift_q;
							rxValid_q <= 1'b1;
							sck_q     <= cpolHigh;
							state_q   <= H_GAP;
						end
						else if (halfDone)
						begin
							bitCnt_q  <= bitCnt_q + lanes;
							txShift_q <= quad ? {txShift_q[3:0], 4'h0} :
								{txShift_q[6:0], 1'b0};
							sck_q     <= 1'b0;
							state_q   <= H_LOW;
						end
					end
				end
				default:
					state_q <= H_IDLE;
			endcase
		end
	end

	// =====================================================================
	// pin drive; write-protect and pause idle high outside quad use
	always_comb
	begin
		link.hostOut = OE_NONE;
		link.hostOe  = OE_NONE;
		if (quad)
		begin
			link.hostOut = txShift_q[7:4];
			link.hostOe  = (inFrame && !readDir) ? OE_ALL : OE_NONE;
		end
		else
		begin
			link.hostOut[LINE_SI] = txShift_q[7];
			link.hostOe[LINE_SI]  = inFrame;
			if (!quadEnableBit)
			begin
				link.hostOut[LINE_WP]    = 1'b1;
				link.hostOe[LINE_WP]     = 1'b1;
				link.hostOut[LINE_PAUSE] = !(pauseReq && inFrame);
				link.hostOe[LINE_PAUSE]  = 1'b1;
			end
		end
	end

	assign link.sck      = sck_q;
	assign link.csN      = csN_q;
	assign link.hwResetN = !hwReset_q;
	assign txReady       = txReady_q;
	assign rxData        = rxData_q;
	assign rxValid       = rxValid_q;
	assign busy          = inFrame;
endmodule
`default_nettype wire

// [testbench/sfpfe_link_monitor.sv]
// Purpose: concurrent checks on the pins between master and flash ends
// Assumes: one clock domain; sys_rst synchronous, active high
// Notes:   flash end sees pins through two flops, so allow a few cycles
`timescale 1ns/1ps
`default_nettype none
module sfpfe_link_monitor (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       sck,
	input wire logic       csN,
	input wire logic       hwResetN,
	input wire logic [3:0] hostOut,
	input wire logic [3:0] hostOe,
	input wire logic [3:0] devOut,
	input wire logic [3:0] devOe,
	input wire logic [3:0] lineLevel
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// =====================================================================
	// release of the flash outputs
	property p_float_idle;
		csN [*5] |-> lineLevel[1:0] == 2'b11;
	endproperty
	a_float_idle: assert property (p_float_idle)
		else $error("lines driven while deselected");
	property p_float_desel;
		$rose(csN) |-> ##[1:4] (devOe == 4'h0);
	endproperty
	a_float_desel: assert property (p_float_desel)
		else $error("flash end kept driving after deselect");
	property p_float_reset;
		!hwResetN [*4] |-> devOe == 4'h0;
	endproperty
	a_float_reset: assert property (p_float_reset)
		else $error("flash end drove lines in hardware reset");
	// pause pin low in a frame; in four-wire writes the flash is silent too
	property p_pause_float;
		(!csN && hostOe[3] && !hostOut[3]) [*5] |-> !devOe[1];
	endproperty
	a_pause_float: assert property (p_pause_float)
		else $error("serial out driven while paused");

	// =====================================================================
	// clock discipline and data timing
	property p_idle_clock;
		csN && $past(csN) |-> $stable(sck);
	endproperty
	a_idle_clock: assert property (p_idle_clock)
		else $error("serial clock moved while idle");
	property p_capture_stable;
		!csN && $rose(sck) |-> $stable(lineLevel[1:0]);
	endproperty
	a_capture_stable: assert property (p_capture_stable)
		else $error("data moved at rising clock");
	property p_launch_fall;
		devOe[1] && $past(devOe[1]) && $changed(devOut[1])
			|-> !sck && !$past(sck, 3);
	endproperty
	a_launch_fall: assert property (p_launch_fall)
		else $error("flash output changed away from a fall");
	property p_output_hold;
		$rose(sck) && devOe[1] |=> $stable(devOut[1]) [*4];
	endproperty
	a_output_hold: assert property (p_output_hold)
		else $error("flash output changed in high half");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: drives both ends of the link from their user sides
// Assumes: the two ends face each other over one link bundle
// Notes:   each scenario except array_map resets first, so no state leaks between them
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("FAIL %s exp %h got %h", nm, e, g); \
		end \
	end
`define WAIT_FOR(c) \
	for (k = 0; k < 400 && (c) !== 1'b1; k++) \
		cyc(1); \
	if ((c) !== 1'b1) \
		give_up();
module tb_top
	import sfpfe_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       cpol, qe, fw, sel, pauseReq, hwReq, rdDir;
	logic [7:0] hTxData, hRxData, dTxData, dRxData;
	logic       hTxValid, hTxReady, hRxValid, busy;
	logic       dTxValid, dTxTaken, dRxValid, dRxReady, dRxRoom;
	logic       selected, paused, inReset;
	int         n_fail = 0;
	int         n_compared = 0;

	// =====================================================================
	// clock and the two ends
	always #2.5 ref_clk = ~ref_clk;
	sfpfe_link_if link ();
	sfpfe_host_end sfpfe_host_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.link(link), .cpolHigh(cpol), .quadEnableBit(qe),
		.fourWireCommandMode(fw), .selectReq(sel), .pauseReq(pauseReq),
		.hwResetReq(hwReq), .readDir(rdDir), .txData(hTxData),
		.txValid(hTxValid), .txReady(hTxReady), .rxData(hRxData),
		.rxValid(hRxValid), .busy(busy));
	sfpfe_device_end sfpfe_device_end_i (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .link(link), .quadEnableBit(qe),
		.fourWireCommandMode(fw), .txData(dTxData), .txValid(dTxValid),
		.txTaken(dTxTaken), .rxData(dRxData), .rxValid(dRxValid),
		.rxReady(dRxReady), .rxRoom(dRxRoom), .selected(selected),
		.paused(paused), .inReset(inReset));
	sfpfe_link_monitor sfpfe_link_monitor_i (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .sck(link.sck), .csN(link.csN),
		.hwResetN(link.hwResetN), .hostOut(link.hostOut),
		.hostOe(link.hostOe), .devOut(link.devOut), .devOe(link.devOe),
		.lineLevel(link.lineLevel));

	// =====================================================================
	// shared tasks
	task automatic final_report();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic give_up();
		n_fail++;
		$display("FAIL wait exp done got stuck");
		final_report();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// csN stays high a while after reset so the flash end arms itself
	task automatic do_reset(input logic cp, input logic q, input logic f);
		sys_rst = 1'b1;
		cpol = cp;
		qe = q;
		fw = f;
		{sel, pauseReq, hwReq, rdDir, hTxValid, dTxValid, dRxReady} = '0;
		hTxData = 8'h00;
		dTxData = 8'h00;
		cyc(6);
		sys_rst = 1'b0;
		cyc(5);
	endtask
	// one byte; done on the host receive pulse, or on flash receive
	task automatic byte_x(input logic [7:0] h, input logic v, input logic w,
		output logic [7:0] got);
		int k;
		hTxData = h;
		hTxValid = v;
		k = 0;
		do
		begin
			cyc(1);
			if (hTxReady === 1'b1)
				hTxValid = 1'b0;
			k++;
		end
		while ((w ? dRxValid : hRxValid) !== 1'b1 && k < 400);
		if ((w ? dRxValid : hRxValid) !== 1'b1)
			give_up();
		got = hRxData;
	endtask
	task automatic close_frame();
		int k;
		sel = 1'b0;
		`WAIT_FOR(!busy)
		cyc(4);
	endtask
	task automatic pop(input logic [7:0] e);
		int k;
		`WAIT_FOR(dRxValid)
		`CHK("flashRx", e, dRxData)
		dRxReady = 1'b1;
		cyc(1);
		dRxReady = 1'b0;
		cyc(1);
	endtask

	// =====================================================================
	// scenarios
	task automatic duplex(input logic cp, input logic [7:0] h0, h1, d0, d1);
		logic [7:0] g;
		int k;
		do_reset(cp, 1'b0, 1'b0);
		`CHK("idleClock", cp, link.sck)
		dTxData = d0;
		dTxValid = 1'b1;
		sel = 1'b1;
		`WAIT_FOR(dTxTaken)
		`CHK("selected", 1'b1, selected)
		dTxData = d1;
		byte_x(h0, 1'b1, 1'b0, g);
		`CHK("hostRx0", d0, g)
		byte_x(h1, 1'b1, 1'b0, g);
		`CHK("hostRx1", d1, g)
		close_frame();
		`CHK("deselected", 1'b0, selected)
		pop(h0);
		pop(h1);
	endtask
	task automatic pause_mid();
		logic [7:0] g;
		do_reset(1'b0, 1'b0, 1'b0);
		dTxData = 8'h69;
		dTxValid = 1'b1;
		sel = 1'b1;
		fork
			byte_x(8'h96, 1'b1, 1'b0, g);
			begin
				cyc(44);
				pauseReq = 1'b1;
				cyc(60);
				`CHK("paused", 1'b1, paused)
				`CHK("soEnable", 1'b0, link.devOe[1])
				`CHK("soWire", 1'b1, link.lineLevel[1])
				pauseReq = 1'b0;
			end
		join
		`CHK("resumedTx", 8'h69, g)
		close_frame();
		pop(8'h96);
	endtask
	task automatic quad_pair();
		logic [7:0] g;
		logic [3:0] nib;
		int k;
		do_reset(1'b0, 1'b1, 1'b1);
		sel = 1'b1;
		fork
			byte_x(8'hb4, 1'b1, 1'b1, g);
			begin
				`WAIT_FOR(link.sck)
				nib = link.lineLevel;
			end
		join
		`CHK("firstNibble", 4'hb, nib)
		close_frame();
		pop(8'hb4);
		dTxData = 8'h7e;
		dTxValid = 1'b1;
		rdDir = 1'b1;
		sel = 1'b1;
		byte_x(8'h00, 1'b0, 1'b0, g);
		`CHK("quadRead", 8'h7e, g)
		close_frame();
	endtask
	task automatic hw_reset();
		logic [7:0] g;
		int k;
		do_reset(1'b1, 1'b1, 1'b0);
		hwReq = 1'b1;
		`WAIT_FOR(inReset)
		cyc(4);
		`CHK("resetFloat", 4'h0, link.devOe)
		`CHK("resetWire", 1'b0, link.hwResetN)
		`CHK("resetDesel", 1'b0, selected)
		hwReq = 1'b0;
		`WAIT_FOR(!inReset)
		cyc(4);
		dTxData = 8'hd2;
		dTxValid = 1'b1;
		sel = 1'b1;
		byte_x(8'h2d, 1'b1, 1'b0, g);
		`CHK("afterReset", 8'hd2, g)
		close_frame();
		pop(8'h2d);
	endtask
	// far side stalls its reads until the buffer refuses a byte
	task automatic fifo_fill();
		logic [7:0] g;
		int i;
		do_reset(1'b0, 1'b0, 1'b0);
		sel = 1'b1;
		for (i = 0; i < 17; i++)
			byte_x(8'h40 + i[7:0], 1'b1, 1'b0, g);
		`CHK("rxRoom", 1'b0, dRxRoom)
		`CHK("floatRead", 8'hff, g)
		close_frame();
		for (i = 0; i < 16; i++)
			pop(8'h40 + i[7:0]);
		`CHK("rxEmpty", 1'b0, dRxValid)
	endtask
	// address map: 4K sectors, sixteen of them to a 64K block
	task automatic array_map();
		`CHK("sectorOf", 12'h00f, sfpfeSectorOf(24'h00f123))
		`CHK("lastSector", 12'h7ff, sfpfeSectorOf(24'h7ff000))
		`CHK("block64Of", 8'h01, sfpfeBlock64Of(24'h01f000))
	endtask

	// =====================================================================
	// main sequence
	initial
	begin
		duplex(1'b0, 8'ha5, 8'h3c, 8'h5a, 8'hc3);
		duplex(1'b1, 8'h81, 8'h7e, 8'h18, 8'he7);
		pause_mid();
		quad_pair();
		hw_reset();
		fifo_fill();
		array_map();
		final_report();
	end
endmodule
`default_nettype wire
